/* File: core/pss_pkg.sv */
// pss_pkg: constants, states and carriers of the scan sequencer
// assumes: every user names items as pss_pkg::name
package pss_pkg;
   // image layout: inputs, outputs, internal bits
   localparam int NP  = 96;
   localparam int NL  = 16;
   localparam int NR  = 16;
   localparam int NY  = 32;
   localparam int XB  = 0;
   localparam int YB  = 32;
   localparam int IB  = 64;
   localparam int NPID = 4;
   // internal group: 64..71 relays, 72..79 timers, 80..87 counter_status_bits, 88..95 stages
   // register byte offsets
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_STAT = 8'h04;
   localparam logic [7:0] A_RET  = 8'h08;
   localparam logic [7:0] A_PID  = 8'h0C;
   localparam logic [7:0] A_FRC  = 8'h10;
   localparam logic [7:0] A_OVX  = 8'h14;
   localparam logic [7:0] A_OVY  = 8'h18;
   localparam logic [7:0] A_OVI  = 8'h1C;
   localparam logic [7:0] A_IMX  = 8'h20;
   localparam logic [7:0] A_IMY  = 8'h24;
   localparam logic [7:0] A_IMI  = 8'h28;
   // control fields
   localparam int C_TRUN = 0;
   localparam int C_EDIT = 1;
   localparam int C_BAD  = 2;
   localparam int C_CLRF = 3;
   localparam int C_CLRN = 4;
   localparam int C_CLRR = 5;
   // force fields
   localparam int F_VAL  = 8;
   localparam int F_PEER = 9;
   // status fields
   localparam int S_CNT  = 16;
   // reset values
   localparam logic [31:0]   RET_RST = 32'h00FF_0000;
   localparam logic [NPID-1:0] PID_RST = 4'h0;
   // mode selector positions
   localparam logic [1:0] SW_PROG = 2'h0;
   localparam logic [1:0] SW_RUN  = 2'h1;
   localparam logic [1:0] SW_TERM = 2'h2;

   typedef enum logic [2:0] {
      ST_INIT, ST_RD_LOC, ST_RD_REM, ST_SERV,
      ST_SOLVE, ST_PID, ST_WR_OUT, ST_DIAG
   } pss_state_e;

   // one bit write: enable, image index, value
   typedef struct packed {
      logic       en;
      logic [6:0] idx;
      logic       val;
   } pss_bw_s;
endpackage

/* File: core/pss_sync.sv */
// pss_sync: two flip-flop synchroniser per bit
// assumes: inputs are asynchronous to hclk
`timescale 1ns/1ns
module pss_sync #(parameter int W = 1) (
   // clock and reset
   input  wire logic         hclk,
   input  wire logic         hresetn,
   // data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic m_q;
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               m_q <= 1'b0;
               q[i] <= 1'b0;
            end else begin
               m_q <= d[i];
               q[i] <= m_q;
            end
         end
      end
   endgenerate
endmodule

/* File: core/pss_bit_img.sv */
// pss_bit_img: bit image store with per-bit override masking
// assumes: contents survive reset; the sequencer clears all but the retentive internal bits at init
`timescale 1ns/1ns
module pss_bit_img (
   // clock
   input  wire logic                  hclk,
   // init clear, peripheral force, scan update, override mask
   input  wire logic [pss_pkg::NP-1:0] clr,
   input  wire logic [pss_pkg::NP-1:0] frc_en,
   input  wire logic                  frc_val,
   input  wire logic [pss_pkg::NP-1:0] upd_en,
   input  wire logic [pss_pkg::NP-1:0] upd_val,
   input  wire logic [pss_pkg::NP-1:0] ovr,
   // image
   output logic      [pss_pkg::NP-1:0] img_q
);
   genvar i;
   generate
      for (i = 0; i < pss_pkg::NP; i++) begin : g_bit
         // force passes an override, scan updates do not
         always_ff @(posedge hclk) begin
            if (clr[i]) begin
               img_q[i] <= 1'b0;
            end else if (frc_en[i]) begin
               img_q[i] <= frc_val;
            end else if (upd_en[i] && !ovr[i]) begin
               img_q[i] <= upd_val[i];
            end
         end
      end
   endgenerate
endmodule

/* File: core/pss_scan_seq.sv */
// pss_scan_seq: scan cycle sequencer with bit image, force and override
// assumes: one ahb-lite master; solver and pid engine on hclk
//
// Functional notes
// R1 - init keeps retentive bits, clears the rest
// R2 - inputs sampled every scan in any mode
// R3 - outputs refreshed in run, off in program
// R4 - program, then configured pid, then outputs
// R5 - non-fatal error reported, mode unchanged
// R6 - fatal error forces program mode, outputs off
// R7 - program mode: no solve, no output writes
// R8 - selector picks mode; terminal position defers
// R9 - run edit holds outputs at last value
// R10 - bad edited program: outputs off, program mode
// R11 - input phase fills image; solver reads image
// R12 - immediate input reads module, not image
// R13 - specialty and remote inputs after local ones
// R14 - remote data taken as given each scan
// R15 - peripherals serviced after input reading
// R16 - regular force lasts until next image write
// R17 - override per input, output, internal bit
// R18 - override freezes bit at current value
// R19 - force still writes an overridden bit
// R20 - overridden bit ignores program and io
// R21 - peer network requests refused bit operations
// R22 - program output write replaces stored force
// R23 - override flags mask scan writes only
//
// Decided for this implementation: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ns
module pss_scan_seq (
   // clock and reset
   input  wire logic                   hclk,
   input  wire logic                   hresetn,
   // ahb-lite slave
   input  wire logic                   hsel,
   input  wire logic [31:0]            haddr,
   input  wire logic [1:0]             htrans,
   input  wire logic                   hwrite,
   input  wire logic [2:0]             hsize,
   input  wire logic [31:0]            hwdata,
   input  wire logic                   hready,
   output logic      [31:0]            hrdata,
   output logic                        hreadyout,
   output logic                        hresp,
   // field pins and remote master
   input  wire logic [pss_pkg::NL-1:0] loc_in,
   input  wire logic [pss_pkg::NR-1:0] rem_in,
   input  wire logic [1:0]             mode_sw,
   output logic      [pss_pkg::NY-1:0] out_pins,
   // diagnostics
   input  wire logic                   fatal_err,
   input  wire logic                   nonfatal_err,
   // program solver and pid engine
   output logic                        slv_start,
   input  wire logic                   slv_done,
   input  wire pss_pkg::pss_bw_s       slv_wr,
   output logic      [pss_pkg::NP-1:0] slv_img,
   input  wire logic [3:0]             imm_idx,
   output logic                        imm_val,
   output logic                        pid_start,
   output logic [pss_pkg::NPID-1:0]    pid_mask,
   input  wire logic                   pid_done,
   // mode indication
   output logic                        run_mode
);
   localparam int NP = pss_pkg::NP;

   // synchronised pins
   logic [pss_pkg::NL-1:0] loc_s;
   logic [pss_pkg::NR-1:0] rem_s;
   logic [1:0]             sw_s;

   pss_sync #(.W(pss_pkg::NL + pss_pkg::NR + 2)) u_sync (
      .hclk    (hclk),
      .hresetn (hresetn),
      .d       ({mode_sw, rem_in, loc_in}),
      .q       ({sw_s, rem_s, loc_s})
   );

   // control state
   pss_pkg::pss_state_e    st_q;
   pss_pkg::pss_state_e    st_d;
   logic                   init_done_q;
   logic                   trun_q;
   logic                   edit_q;
   logic                   fault_q;
   logic                   nf_q;
   logic                   refused_q;
   logic [31:0]            ret_q;
   logic [pss_pkg::NPID-1:0] pid_cfg_q;
   logic [31:0]            ovx_q;
   logic [31:0]            ovy_q;
   logic [31:0]            ovi_q;
   pss_pkg::pss_bw_s       frc_q;
   logic [15:0]            cnt_q;
   logic                   slv_start_q;
   logic                   pid_start_q;
   logic                   eng_q;   // engine started, answer pending
   logic [pss_pkg::NY-1:0] out_q;
   logic                   imm_q;

   // ahb-lite address phase capture
   logic                   wr_q;
   logic [7:0]             wa_q;
   logic [31:0]            hrdata_q;
   logic [31:0]            rd_mux;
   logic [NP-1:0]          img_q;

   wire logic ap      = hsel && hready && htrans[1];
   wire logic hi_ok   = (haddr[31:8] == 24'h000000);
   wire logic w_ctrl  = wr_q && (wa_q == pss_pkg::A_CTRL);
   wire logic w_frc   = wr_q && (wa_q == pss_pkg::A_FRC);
   wire logic bad_w   = w_ctrl && hwdata[pss_pkg::C_BAD];
   wire logic clrf_w  = w_ctrl && hwdata[pss_pkg::C_CLRF];
   wire logic clrn_w  = w_ctrl && hwdata[pss_pkg::C_CLRN];
   wire logic clrr_w  = w_ctrl && hwdata[pss_pkg::C_CLRR];
   wire logic peer_w  = w_frc && hwdata[pss_pkg::F_PEER];

   // mode selection
   wire logic sel_run = (sw_s == pss_pkg::SW_RUN)
                        || ((sw_s == pss_pkg::SW_TERM) && trun_q);   // R8
   assign run_mode    = sel_run && !fault_q;                           // R6
   wire logic exec    = run_mode && !edit_q;                           // R7

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (!hi_ok) begin
         rd_mux = 32'h0000_0000;
      end else if (haddr[7:0] == pss_pkg::A_CTRL) begin
         rd_mux = {30'h0000_0000, edit_q, trun_q};
      end else if (haddr[7:0] == pss_pkg::A_STAT) begin
         rd_mux = {cnt_q, 5'h00, st_q, 2'h0, frc_q.en,
                   init_done_q, refused_q, nf_q, fault_q, run_mode};
      end else if (haddr[7:0] == pss_pkg::A_RET) begin
         rd_mux = ret_q;
      end else if (haddr[7:0] == pss_pkg::A_PID) begin
         rd_mux = {28'h000_0000, pid_cfg_q};
      end else if (haddr[7:0] == pss_pkg::A_OVX) begin
         rd_mux = ovx_q;
      end else if (haddr[7:0] == pss_pkg::A_OVY) begin
         rd_mux = ovy_q;
      end else if (haddr[7:0] == pss_pkg::A_OVI) begin
         rd_mux = ovi_q;
      end else if (haddr[7:0] == pss_pkg::A_IMX) begin
         rd_mux = slv_img[pss_pkg::XB +: 32];
      end else if (haddr[7:0] == pss_pkg::A_IMY) begin
         rd_mux = slv_img[pss_pkg::YB +: 32];
      end else if (haddr[7:0] == pss_pkg::A_IMI) begin
         rd_mux = slv_img[pss_pkg::IB +: 32];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q     <= 1'b0;
         wa_q     <= 8'h00;
         hrdata_q <= 32'h0000_0000;
      end else begin
         wr_q     <= ap && hwrite && hi_ok;
         wa_q     <= haddr[7:0];
         hrdata_q <= (ap && !hwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   assign hrdata    = hrdata_q;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // software registers; hardware sets win over software clears
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         trun_q    <= 1'b0;
         edit_q    <= 1'b0;
         fault_q   <= 1'b0;
         nf_q      <= 1'b0;
         refused_q <= 1'b0;
         ret_q     <= pss_pkg::RET_RST;
         pid_cfg_q <= pss_pkg::PID_RST;
         ovx_q     <= 32'h0000_0000;
         ovy_q     <= 32'h0000_0000;
         ovi_q     <= 32'h0000_0000;
      end else begin
         if (w_ctrl) begin
            trun_q <= hwdata[pss_pkg::C_TRUN];
            edit_q <= hwdata[pss_pkg::C_EDIT];
         end
         if (fatal_err || bad_w) begin
            fault_q <= 1'b1;                                           // R6 R10
         end else if (clrf_w) begin
            fault_q <= 1'b0;
         end
         if (nonfatal_err) begin
            nf_q <= 1'b1;                                              // R5
         end else if (clrn_w) begin
            nf_q <= 1'b0;
         end
         if (peer_w) begin
            refused_q <= 1'b1;                                         // R21
         end else if (clrr_w) begin
            refused_q <= 1'b0;
         end
         if (wr_q && (wa_q == pss_pkg::A_RET)) begin
            ret_q <= hwdata;
         end
         if (wr_q && (wa_q == pss_pkg::A_PID)) begin
            pid_cfg_q <= hwdata[pss_pkg::NPID-1:0];
         end
         if (wr_q && (wa_q == pss_pkg::A_OVX)) begin
            ovx_q <= hwdata;                                           // R17
         end
         if (wr_q && (wa_q == pss_pkg::A_OVY)) begin
            ovy_q <= hwdata;
         end
         if (wr_q && (wa_q == pss_pkg::A_OVI)) begin
            ovi_q <= hwdata;
         end
      end
   end

   // pending peripheral force, applied in the service phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         frc_q <= '0;
      end else if (w_frc && !peer_w) begin
         frc_q <= '{en: 1'b1, idx: hwdata[6:0], val: hwdata[pss_pkg::F_VAL]};
      end else if (st_q == pss_pkg::ST_SERV) begin
         frc_q.en <= 1'b0;
      end
   end

   // scan sequence
   always_comb begin
      st_d = st_q;
      case (st_q)
         pss_pkg::ST_INIT: begin
            st_d = pss_pkg::ST_RD_LOC;
         end
         pss_pkg::ST_RD_LOC: begin
            st_d = pss_pkg::ST_RD_REM;                                 // R13
         end
         pss_pkg::ST_RD_REM: begin
            st_d = pss_pkg::ST_SERV;                                   // R15
         end
         pss_pkg::ST_SERV: begin
            st_d = pss_pkg::ST_SOLVE;
         end
         pss_pkg::ST_SOLVE: begin
            if (!exec || (!slv_start_q && (!eng_q || slv_done))) begin
               st_d = pss_pkg::ST_PID;                                 // R4
            end
         end
         pss_pkg::ST_PID: begin
            if (!exec || (pid_cfg_q == 4'h0) || (!pid_start_q && (!eng_q || pid_done))) begin
               st_d = pss_pkg::ST_WR_OUT;
            end
         end
         pss_pkg::ST_WR_OUT: begin
            st_d = pss_pkg::ST_DIAG;
         end
         pss_pkg::ST_DIAG: begin
            st_d = pss_pkg::ST_RD_LOC;
         end
         default: begin
            st_d = pss_pkg::ST_INIT;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q        <= pss_pkg::ST_INIT;
         init_done_q <= 1'b0;
         cnt_q       <= 16'h0000;
         slv_start_q <= 1'b0;
         pid_start_q <= 1'b0;
         eng_q       <= 1'b0;
      end else begin
         st_q        <= st_d;
         init_done_q <= init_done_q || (st_q == pss_pkg::ST_INIT);
         cnt_q       <= cnt_q + {15'h0000, st_q == pss_pkg::ST_DIAG};
         slv_start_q <= (st_q == pss_pkg::ST_SERV) && exec;           // R7
         pid_start_q <= (st_q == pss_pkg::ST_SOLVE) && (st_d == pss_pkg::ST_PID)
                        && exec && (pid_cfg_q != 4'h0);
         eng_q       <= slv_start_q || pid_start_q || (eng_q && !(slv_done || pid_done));
      end
   end

   assign slv_start = slv_start_q;
   assign pid_start = pid_start_q;
   assign pid_mask  = pid_cfg_q;                                       // R4

   // image write paths
   wire logic [NP-1:0] one   = {{(NP - 1){1'b0}}, 1'b1};
   wire logic [NP-1:0] ovr   = {ovi_q, ovy_q, ovx_q};
   wire logic          in_sp = (st_q == pss_pkg::ST_SOLVE) || (st_q == pss_pkg::ST_PID);
   wire logic          sw_ok = slv_wr.en && in_sp && exec && (slv_wr.idx < 7'd96);
   wire logic          fr_ok = frc_q.en && (st_q == pss_pkg::ST_SERV) && (frc_q.idx < 7'd96);
   wire logic [NP-1:0] slv_1h = sw_ok ? (one << slv_wr.idx) : '0;
   wire logic [NP-1:0] frc_1h = fr_ok ? (one << frc_q.idx) : '0;     // R16 R19
   wire logic [NP-1:0] clr    = (st_q == pss_pkg::ST_INIT) ? {~ret_q, {64{1'b1}}} : '0; // R1
   wire logic [NP-1:0] loc_en = (st_q == pss_pkg::ST_RD_LOC) ? {80'h0, 16'hFFFF} : '0; // R2 R11
   wire logic [NP-1:0] rem_en = (st_q == pss_pkg::ST_RD_REM) ? {64'h0, 16'hFFFF, 16'h0} : '0; // R13 R14
   wire logic [NP-1:0] upd_en = loc_en | rem_en | slv_1h;             // R22
   wire logic [NP-1:0] upd_val = {64'h0, rem_s, loc_s} | (slv_wr.val ? slv_1h : '0);

   pss_bit_img u_img (
      .hclk    (hclk),
      .clr     (clr),
      .frc_en  (frc_1h),
      .frc_val (frc_q.val),
      .upd_en  (upd_en),
      .upd_val (upd_val),
      .ovr     (ovr),                                                  // R18 R20 R23
      .img_q   (img_q)
   );

   assign slv_img = init_done_q ? img_q : '0;                          // R11

   // outputs and immediate input
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         out_q <= '0;
         imm_q <= 1'b0;
      end else begin
         imm_q <= loc_s[imm_idx];                                      // R12
         if (!run_mode) begin
            out_q <= '0;                                               // R3 R6
         end else if ((st_q == pss_pkg::ST_WR_OUT) && !edit_q) begin
            out_q <= img_q[pss_pkg::YB +: pss_pkg::NY];                // R9
         end
      end
   end

   assign out_pins = out_q;
   assign imm_val  = imm_q;

   // checks
   a_prog_outs_off: assert property (@(posedge hclk) disable iff (!hresetn) // R3
      !run_mode |=> (out_pins == '0)) else $error("outputs on outside run");
   a_fatal_to_prog: assert property (@(posedge hclk) disable iff (!hresetn) // R6
      fatal_err |=> (fault_q && !run_mode) ##1 (out_pins == '0)) else $error("fatal not handled");
   a_nonfatal_keep: assert property (@(posedge hclk) disable iff (!hresetn) // R5
      (nonfatal_err && !fatal_err && !bad_w && !clrf_w) |=> (nf_q && $stable(fault_q)))
      else $error("non-fatal changed mode");
   a_edit_bad_off: assert property (@(posedge hclk) disable iff (!hresetn) // R10
      bad_w |-> ##2 (!run_mode && out_pins == '0)) else $error("bad edit not stopped");
   a_edit_hold: assert property (@(posedge hclk) disable iff (!hresetn) // R9
      (edit_q && run_mode && st_q == pss_pkg::ST_WR_OUT) |=> $stable(out_pins))
      else $error("outputs moved during edit");
   a_pid_after_prog: assert property (@(posedge hclk) disable iff (!hresetn) // R4
      pid_start |-> ($past(st_q) == pss_pkg::ST_SOLVE && st_q == pss_pkg::ST_PID))
      else $error("pid out of order");
   a_no_solve_prog: assert property (@(posedge hclk) disable iff (!hresetn) // R7
      slv_start |-> ($past(run_mode) && st_q == pss_pkg::ST_SOLVE)) else $error("solve in program");
   a_init_clear: assert property (@(posedge hclk) disable iff (!hresetn) // R1
      (st_q == pss_pkg::ST_INIT) |=> ((img_q[63:0] == 64'h0) && init_done_q))
      else $error("init did not clear");
   a_input_sample: assert property (@(posedge hclk) disable iff (!hresetn) // R2
      (st_q == pss_pkg::ST_RD_LOC) |=> (((img_q[15:0] ^ $past(loc_s)) & ~$past(ovx_q[15:0])) == 16'h0))
      else $error("input image not sampled");
   a_ovr_frozen: assert property (@(posedge hclk) disable iff (!hresetn) // R20
      (st_q != pss_pkg::ST_INIT && frc_1h == '0) |=> (((img_q ^ $past(img_q)) & $past(ovr)) == '0))
      else $error("overridden bit changed");
   a_peer_refused: assert property (@(posedge hclk) disable iff (!hresetn) // R21
      (peer_w && !frc_q.en) |=> (!frc_q.en && refused_q)) else $error("peer force accepted");
endmodule

/* File: test/pss_solver_model.sv */
// pss_solver_model: behavioural program solver and pid engine
// assumes: start pulses come from pss_scan_seq on hclk; the bench picks the bit written
`timescale 1ns/1ns
module pss_solver_model (
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // sequencer side
   input  wire logic        slv_start,
   output pss_pkg::pss_bw_s slv_wr,
   output logic             slv_done,
   input  wire logic        pid_start,
   output logic             pid_done,
   // bench control
   input  wire logic        slow,
   input  wire logic [6:0]  wr_idx,
   input  wire logic        wr_val
);
   logic       busy_q;
   logic [2:0] cnt_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         busy_q   <= 1'b0;
         cnt_q    <= 3'h0;
         slv_done <= 1'b0;
         slv_wr   <= '0;
         pid_done <= 1'b0;
      end else begin
         slv_done <= 1'b0;
         slv_wr   <= '0;
         pid_done <= pid_start;
         if (slv_start) begin
            busy_q <= 1'b1;
            cnt_q  <= slow ? 3'h4 : 3'h0;
         end else if (busy_q && cnt_q == 3'h0) begin
            busy_q   <= 1'b0;
            slv_done <= 1'b1;
            slv_wr   <= '{en: 1'b1, idx: wr_idx, val: wr_val};
         end else if (busy_q) begin
            cnt_q <= cnt_q - 3'h1;
         end
      end
   end
endmodule

/* File: test/tb_plc_scan_sequencer.sv */
// tb_plc_scan_sequencer: self-checking bench for pss_scan_seq
// assumes: zero-wait ahb-lite slave; solver model answers every start pulse
`timescale 1ns/1ns
module tb_plc_scan_sequencer;
   logic             hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0]      haddr, hwdata, hrdata, rd, out_pins;
   logic [1:0]       htrans, mode_sw;
   logic [2:0]       hsize;
   logic [15:0]      loc_in, rem_in;
   logic             fatal_err, nonfatal_err, slv_start, slv_done, pid_start, pid_done;
   logic             imm_val, run_mode, slow, wr_val;
   pss_pkg::pss_bw_s slv_wr;
   logic [95:0]      slv_img;
   logic [3:0]       imm_idx, pid_mask;
   logic [6:0]       wr_idx;
   int               errors, cmp_count, n_slv, n_pid;

   assign hready = hreadyout;
   always #5 hclk = ~hclk;
   always @(posedge hclk) begin
      if (slv_start === 1'b1) n_slv++;
      if (pid_start === 1'b1) n_pid++;
   end

   pss_scan_seq uut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .loc_in(loc_in), .rem_in(rem_in),
      .mode_sw(mode_sw), .out_pins(out_pins), .fatal_err(fatal_err),
      .nonfatal_err(nonfatal_err), .slv_start(slv_start), .slv_done(slv_done),
      .slv_wr(slv_wr), .slv_img(slv_img), .imm_idx(imm_idx), .imm_val(imm_val),
      .pid_start(pid_start), .pid_mask(pid_mask), .pid_done(pid_done), .run_mode(run_mode)
   );
   pss_solver_model model (
      .hclk(hclk), .hresetn(hresetn), .slv_start(slv_start), .slv_wr(slv_wr),
      .slv_done(slv_done), .pid_start(pid_start), .pid_done(pid_done),
      .slow(slow), .wr_idx(wr_idx), .wr_val(wr_val)
   );

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         $display("mismatch %s expected %h seen %h", nm, exp, got);
         errors++;
      end
   endtask
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
      int n;
      @(posedge hclk);
      hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w;
      n = 0;
      do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 20);
      if (hready !== 1'b1) n = 40;
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
      do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 40);
      rd = hrdata;
      if (n >= 40) begin errors++; give_verdict(); end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      ahb(1'b1, {24'h0, a}, d);
   endtask
   task automatic rdreg(input logic [7:0] a);
      ahb(1'b0, {24'h0, a}, 32'h0);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask
   // waits for n completed scans by watching the scan counter
   task automatic scans(input int n);
      logic [15:0] c0;
      int k;
      rdreg(pss_pkg::A_STAT);
      c0 = rd[31:16];
      for (k = 0; k < 300; k++) begin
         rdreg(pss_pkg::A_STAT);
         if (rd[31:16] - c0 >= 16'(n)) break;
      end
      if (k == 300) begin errors++; give_verdict(); end
   endtask
   task automatic do_reset;
      hresetn <= 1'b0;
      cyc(5);
      hresetn <= 1'b1;
   endtask
   task automatic pulse_err(input logic fat);
      @(posedge hclk);
      if (fat) fatal_err <= 1'b1;
      else nonfatal_err <= 1'b1;
      @(posedge hclk);
      fatal_err <= 1'b0; nonfatal_err <= 1'b0;
   endtask

   task automatic t_init;
      scans(2);
      rdreg(pss_pkg::A_STAT); chk("init_done", 32'h1, {31'h0, rd[4]});
      rdreg(pss_pkg::A_IMY); chk("out_image", 32'h0, rd);
      rdreg(pss_pkg::A_IMI); chk("internal_clear", 32'h0, rd & 32'hFF00_FFFF);
      wr(pss_pkg::A_FRC, 32'h0000_0140);
      scans(2);
      wr(pss_pkg::A_FRC, 32'h0000_0150);
      scans(2);
      do_reset();
      scans(2);
      rdreg(pss_pkg::A_IMI); chk("retained", 32'h0001_0000, rd & 32'hFF01_FFFF);
      $display("test init done");
   endtask
   task automatic t_prog;
      loc_in <= 16'hA5C3; rem_in <= 16'h3C1E;
      scans(2);
      rdreg(pss_pkg::A_IMX); chk("in_image", 32'h3C1E_A5C3, rd);
      chk("out_off", 32'h0, out_pins);
      chk("no_solve", 32'h0, 32'(n_slv));
      wr(pss_pkg::A_FRC, 32'h0000_0341);
      scans(1);
      rdreg(pss_pkg::A_IMI); chk("peer_bit", 32'h0, {31'h0, rd[1]});
      rdreg(pss_pkg::A_STAT); chk("peer_refused", 32'h1, {31'h0, rd[3]});
      ahb(1'b0, 32'h0000_0100, 32'h0); chk("unmapped", 32'h0, rd);
      chk("hresp", 32'h0, {31'h0, hresp});
      wr(pss_pkg::A_CTRL, 32'h20);
      $display("test program mode done");
   endtask
   task automatic t_run;
      slow <= 1'b1; wr_idx <= 7'd37; wr_val <= 1'b1;
      wr(pss_pkg::A_PID, 32'h3);
      mode_sw <= pss_pkg::SW_RUN;
      scans(3);
      chk("run", 32'h1, {31'h0, run_mode});
      chk("out_solved", 32'h20, out_pins & 32'h20);
      chk("pid_mask", 32'h3, {28'h0, pid_mask});
      chk("pid_ran", 32'h1, {31'h0, n_pid > 0});
      wr(pss_pkg::A_FRC, 32'h0000_0025); scans(2);
      chk("program_beats_force", 32'h20, out_pins & 32'h20);
      wr(pss_pkg::A_FRC, 32'h0000_0126); scans(2);
      chk("force_kept", 32'h40, out_pins & 32'h40);
      wr(pss_pkg::A_FRC, 32'h0000_0000); scans(2);
      rdreg(pss_pkg::A_IMX); chk("force_one_scan", 32'h1, rd & 32'h1);
      imm_idx <= 4'h3; loc_in <= 16'hA5CB; cyc(4);
      chk("immediate_hi", 32'h1, {31'h0, imm_val});
      loc_in <= 16'hA5C3; cyc(4);
      chk("immediate_lo", 32'h0, {31'h0, imm_val});
      $display("test run mode done");
   endtask
   task automatic t_ovr;
      wr(pss_pkg::A_OVY, 32'h20); wr_val <= 1'b0; scans(2);
      chk("ovr_hold", 32'h20, out_pins & 32'h20);
      wr(pss_pkg::A_FRC, 32'h0000_0025); scans(2);
      chk("ovr_force_off", 32'h0, out_pins & 32'h20);
      wr_val <= 1'b1;
      wr(pss_pkg::A_FRC, 32'h0000_0125); wr_val <= 1'b0; scans(2);
      chk("ovr_force_on", 32'h20, out_pins & 32'h20);
      wr(pss_pkg::A_OVY, 32'h0); scans(2);
      chk("ovr_removed", 32'h0, out_pins & 32'h20);
      wr_val <= 1'b1; scans(2);
      $display("test override done");
   endtask
   task automatic t_edit;
      wr(pss_pkg::A_CTRL, 32'h2); wr_val <= 1'b0; scans(2);
      chk("edit_hold", 32'h20, out_pins & 32'h20);
      wr(pss_pkg::A_CTRL, 32'h6); cyc(3);
      chk("bad_edit_mode", 32'h0, {31'h0, run_mode});
      chk("bad_edit_out", 32'h0, out_pins);
      wr(pss_pkg::A_CTRL, 32'h8); wr_val <= 1'b1; scans(2);
      $display("test edit done");
   endtask
   task automatic t_err;
      pulse_err(1'b0); cyc(3);
      rdreg(pss_pkg::A_STAT); chk("nonfatal_flag", 32'h1, {31'h0, rd[2]});
      chk("nonfatal_run", 32'h1, {31'h0, run_mode});
      chk("nonfatal_out", 32'h20, out_pins & 32'h20);
      pulse_err(1'b1); cyc(3);
      chk("fatal_mode", 32'h0, {31'h0, run_mode});
      chk("fatal_out", 32'h0, out_pins);
      wr(pss_pkg::A_CTRL, 32'h18); scans(2);
      chk("fault_cleared", 32'h1, {31'h0, run_mode});
      $display("test errors done");
   endtask
   task automatic t_term;
      mode_sw <= pss_pkg::SW_TERM; wr(pss_pkg::A_CTRL, 32'h0); scans(2);
      chk("term_prog", 32'h0, {31'h0, run_mode});
      wr(pss_pkg::A_CTRL, 32'h1); scans(2);
      chk("term_run", 32'h1, {31'h0, run_mode});
      mode_sw <= pss_pkg::SW_PROG; scans(2);
      chk("prog_out_off", 32'h0, out_pins);
      $display("test selector done");
   endtask

   initial begin
      hclk = 1'b0; hresetn = 1'b0; hsel = 1'b0; hwrite = 1'b0; htrans = 2'h0;
      haddr = 32'h0; hwdata = 32'h0; hsize = 3'h2; loc_in = 16'h0; rem_in = 16'h0;
      mode_sw = pss_pkg::SW_PROG; fatal_err = 1'b0; nonfatal_err = 1'b0; imm_idx = 4'h0;
      slow = 1'b0; wr_idx = 7'h0; wr_val = 1'b0;
      errors = 0; cmp_count = 0; n_slv = 0; n_pid = 0;
      do_reset();
      t_init();
      t_prog();
      t_run();
      t_ovr();
      t_edit();
      t_err();
      t_term();
      give_verdict();
   end
endmodule
